// file: logic/vpr_defs.svh
// register offsets, status field positions, mode codes and timing figures
// assumes nothing; included by the register bank alone
`ifndef VPR_DEFS_SVH
`define VPR_DEFS_SVH

// word offsets of the shared memory registers
`define VPR_OFF_RAM_PTR    4'h0
`define VPR_OFF_RAM_DATA   4'h1
`define VPR_OFF_POS_FB     4'h2
`define VPR_OFF_COIL_ONE   4'h3
`define VPR_OFF_COIL_TWO   4'h4
`define VPR_OFF_COIL_THREE 4'h5
`define VPR_OFF_DEMOD      4'h6
`define VPR_OFF_STAT2      4'h7
`define VPR_OFF_STAT1      4'h8

// primary status word bit positions
`define VPR_BIT_SHUTDOWN   4
`define VPR_BIT_AUX_SENSE  5
`define VPR_BIT_SLIM_EN    6
`define VPR_BIT_ALIVE      7
`define VPR_BIT_AT_NULL    8
`define VPR_BIT_QUALITY    9
`define VPR_BIT_BACKUP     10
`define VPR_BIT_LVDT       11
`define VPR_BIT_FAILOVER   12
`define VPR_BIT_DEMAND_ERR 13
`define VPR_BIT_MODE_MM    14
`define VPR_BIT_NV_DONE    15

// mode codes
`define VPR_MODE_UNUSED    4'h0
`define VPR_MODE_PWR_ENTRY 4'h1
`define VPR_MODE_START     4'h2
`define VPR_MODE_TEST      4'h3
`define VPR_MODE_LOCAL     4'h8
`define VPR_MODE_NORMAL    4'hc
`define VPR_CLS_LOCAL      2'h2
`define VPR_CLS_NORMAL     2'h3

// reset values
`define VPR_RST_MODE       4'h1
`define VPR_RST_WORD       16'h0000

// position scaling: counts = percent * 312, percent given in q8
`define VPR_POS_SCALE      32'sd312
`define VPR_POS_FRAC       8
`define VPR_POS_MIN        (-32'sd1560)
`define VPR_POS_MAX        32'sd32760

// timing
`define VPR_CLK_HZ         20000000
`define VPR_HOLD_MS        5000
`define VPR_ALIVE_MS       10
`define VPR_HOLD_CYC       (`VPR_HOLD_MS * (`VPR_CLK_HZ / 1000))
`define VPR_ALIVE_CYC      (`VPR_ALIVE_MS * (`VPR_CLK_HZ / 1000))

`endif

// file: logic/vpr_pkg.sv
// types shared by the valve positioner register bank
// enum codes are its own, not the VPR_CLS_LOCAL and VPR_CLS_NORMAL values of vpr_defs.svh
package vpr_pkg;

	// one shared memory word
	typedef logic [15:0] vpr_word_t;

	// four-bit operating mode code
	typedef logic [3:0] vpr_mode_t;

	// class of an operating mode
	typedef enum logic [1:0] {
		VPR_CLS_OTHER,
		VPR_CLS_LOCAL,
		VPR_CLS_NORMAL
	} vpr_mode_cls_t;

endpackage

// file: logic/vpr_hold_timer.sv
// retriggerable hold: keeps its output high for a fixed count of cycles
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/1ps
module vpr_hold_timer #(
	parameter int HOLD_CYCLES = 100000000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// trigger and held level
	input  wire logic trig,
	output logic      active
);

	localparam int CW = $clog2(HOLD_CYCLES + 1);

	logic [CW-1:0] cnt_ff;

	// load on trigger, then count down to zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (trig) begin
			cnt_ff <= CW'(HOLD_CYCLES);
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - CW'(1);
		end
	end

	// high for exactly HOLD_CYCLES cycles after the last trigger
	assign active = (cnt_ff != '0);

endmodule

// file: logic/vpr_host_regs.sv
// host-facing shared memory register bank of a valve positioner card
// assumes a host port with word address, one-cycle read and write strobes,
// firmware-side inputs on REF_CLK and three field pins from outside
//
// Summary of operation
// - position feedback: percent times 312, clamped
// - mode bits 3:0, 1 entry 2 start 3 test
// - local modes use codes 1000 to 1011
// - normal modes use codes 1100 to 1111
// - bit 4 shows the shutdown input
// - bit 7 toggles while firmware runs
// - bit 8 set at transducer null point
// - bit 9 quality, bit 10 backup role
// - bit 11 held five seconds on transducer fault
// - bit 12 held five seconds on role change
// - bit 13 set when the two demands differ
// - bit 14 set on normal versus local mismatch
// - bit 15 set when nonvolatile write completes
// - test mode keeps mode bits, rest differs
// - secondary status word reads all zero
// - coils two and three valid only non-redundant
// - offset 0 ram pointer, offset 1 its data
// - bit 5 auxiliary sense, bit 6 slim enable
`timescale 1ns/1ps
`include "vpr_defs.svh"
module vpr_host_regs #(
	parameter int HOLD_CYCLES  = `VPR_HOLD_CYC,
	parameter int ALIVE_CYCLES = `VPR_ALIVE_CYC,
	parameter int RAM_DEPTH    = 256
) (
	// clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              NRST,
	// host shared memory port
	input  wire logic [3:0]        HOST_ADDR,
	input  wire logic              HOST_RD,
	input  wire logic              HOST_WR,
	input  wire vpr_pkg::vpr_word_t HOST_WDATA,
	output vpr_pkg::vpr_word_t     HOST_RDATA,
	// field pins, asynchronous
	input  wire logic              SHUTDOWN_IN,
	input  wire logic              AUX_SENSE_IN,
	input  wire logic              SLIM_EN_IN,
	// measurements from the firmware side
	input  wire logic signed [15:0] POS_PCT_Q8,
	input  wire vpr_pkg::vpr_word_t COIL_ONE,
	input  wire vpr_pkg::vpr_word_t COIL_TWO,
	input  wire vpr_pkg::vpr_word_t COIL_THREE,
	input  wire vpr_pkg::vpr_word_t DEMOD_RAW,
	// firmware state
	input  wire logic              FW_RUNNING,
	input  wire vpr_pkg::vpr_mode_t FW_MODE,
	input  wire logic              AT_NULL,
	input  wire vpr_pkg::vpr_word_t TEST_STATUS,
	input  wire logic              NV_WRITE_START,
	input  wire logic              NV_WRITE_DONE,
	// redundancy
	input  wire logic              REDUNDANT,
	input  wire logic              UNIT_BACKUP,
	input  wire logic              QUALITY_BAD,
	input  wire logic              LVDT_FAULT,
	input  wire vpr_pkg::vpr_mode_t PARTNER_MODE,
	input  wire vpr_pkg::vpr_word_t HOST_DEMAND,
	input  wire vpr_pkg::vpr_word_t LINK_DEMAND,
	// device side of the indirect ram
	input  wire logic [15:0]       DEV_RAM_ADDR,
	output vpr_pkg::vpr_word_t     DEV_RAM_RDATA,
	output logic [15:0]            RAM_PUT_PTR,
	// status word as seen by the host
	output vpr_pkg::vpr_word_t     STATUS_WORD
);

	localparam int PW = $clog2(RAM_DEPTH);
	localparam int AW = $clog2(ALIVE_CYCLES);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [2:0]          sync1_ff;
	logic [2:0]          sync2_ff;
	logic                shutdown;
	logic                aux_sense;
	logic                slim_en;

	vpr_pkg::vpr_mode_t  mode_ff;
	logic                mode_ok;
	logic                test_mode;

	logic signed [31:0]  pos_prod;
	logic signed [31:0]  pos_shift;
	logic signed [31:0]  nxt_pos;
	vpr_pkg::vpr_word_t  pos_fb_ff;
	vpr_pkg::vpr_word_t  coil_one_ff;
	vpr_pkg::vpr_word_t  coil_two_ff;
	vpr_pkg::vpr_word_t  coil_three_ff;
	vpr_pkg::vpr_word_t  demod_ff;

	logic [AW-1:0]       alive_cnt_ff;
	logic                alive_ff;

	logic                role_q_ff;
	logic                lvdt_q_ff;
	logic                lvdt_trig;
	logic                fail_trig;
	logic                lvdt_hold;
	logic                fail_hold;
	logic                demand_err_ff;
	logic                mode_mm_ff;
	logic                nv_done_ff;

	vpr_pkg::vpr_word_t  nxt_stat;
	vpr_pkg::vpr_word_t  stat_ff;

	logic [15:0]         ptr_ff;
	vpr_pkg::vpr_word_t  ram [RAM_DEPTH];
	vpr_pkg::vpr_word_t  nxt_rdata;
	vpr_pkg::vpr_word_t  rdata_ff;
	vpr_pkg::vpr_word_t  dev_rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// classify a mode code as local, normal or other
	function automatic vpr_pkg::vpr_mode_cls_t mode_class(vpr_pkg::vpr_mode_t m);
		vpr_pkg::vpr_mode_cls_t c;
		c = vpr_pkg::VPR_CLS_OTHER;
		if (m[3:2] == `VPR_CLS_LOCAL) begin
			c = vpr_pkg::VPR_CLS_LOCAL;
		end else if (m[3:2] == `VPR_CLS_NORMAL) begin
			c = vpr_pkg::VPR_CLS_NORMAL;
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// field pin synchronisers

	// two flip-flops per pin before anything reads it
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
		end else begin
			sync1_ff <= {SLIM_EN_IN, AUX_SENSE_IN, SHUTDOWN_IN};
			sync2_ff <= sync1_ff;
		end
	end

	assign shutdown  = sync2_ff[0];
	assign aux_sense = sync2_ff[1];
	assign slim_en   = sync2_ff[2];

	////////////////////////////////////////////////////////////////////////
	// operating mode

	// only documented codes are accepted; unused codes keep the last mode
	always_comb begin
		case (FW_MODE)
			`VPR_MODE_PWR_ENTRY: mode_ok = 1'b1;
			`VPR_MODE_START:     mode_ok = 1'b1;
			`VPR_MODE_TEST:      mode_ok = 1'b1;
			default:             mode_ok = FW_MODE[3];
		endcase
	end

	// mode register, power-entry after reset
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			mode_ff <= `VPR_RST_MODE;
		end else if (mode_ok) begin
			mode_ff <= FW_MODE;
		end
	end

	assign test_mode = (mode_ff == `VPR_MODE_TEST);

	////////////////////////////////////////////////////////////////////////
	// measurements

	// percent in q8 times 312 gives -1560 at -5 and 32760 at 105
	assign pos_prod  = 32'(POS_PCT_Q8) * `VPR_POS_SCALE;
	assign pos_shift = pos_prod >>> `VPR_POS_FRAC;

	// clamp to the reporting span
	always_comb begin
		nxt_pos = pos_shift;
		if (pos_shift < `VPR_POS_MIN) begin
			nxt_pos = `VPR_POS_MIN;
		end else if (pos_shift > `VPR_POS_MAX) begin
			nxt_pos = `VPR_POS_MAX;
		end
	end

	// sample measurements every cycle
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			pos_fb_ff     <= `VPR_RST_WORD;
			coil_one_ff   <= `VPR_RST_WORD;
			coil_two_ff   <= `VPR_RST_WORD;
			coil_three_ff <= `VPR_RST_WORD;
			demod_ff      <= `VPR_RST_WORD;
		end else begin
			pos_fb_ff   <= nxt_pos[15:0];
			coil_one_ff <= COIL_ONE;
			demod_ff    <= DEMOD_RAW;
			if (REDUNDANT) begin
				coil_two_ff   <= `VPR_RST_WORD;
				coil_three_ff <= `VPR_RST_WORD;
			end else begin
				coil_two_ff   <= COIL_TWO;
				coil_three_ff <= COIL_THREE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alive flag

	// invert the flag every ALIVE_CYCLES while firmware runs
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			alive_cnt_ff <= '0;
			alive_ff     <= 1'b0;
		end else if (!FW_RUNNING) begin
			alive_cnt_ff <= '0;
		end else if (alive_cnt_ff == AW'(ALIVE_CYCLES - 1)) begin
			alive_cnt_ff <= '0;
			alive_ff     <= ~alive_ff;
		end else begin
			alive_cnt_ff <= alive_cnt_ff + AW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// redundancy annunciators

	// edge detect for role change and transducer fault
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			role_q_ff <= UNIT_BACKUP; // tracks in reset: no false failover
			lvdt_q_ff <= 1'b0;
		end else begin
			role_q_ff <= UNIT_BACKUP;
			lvdt_q_ff <= LVDT_FAULT;
		end
	end

	assign lvdt_trig = REDUNDANT && LVDT_FAULT && !lvdt_q_ff;
	assign fail_trig = REDUNDANT && (UNIT_BACKUP != role_q_ff);

	// five second hold for transducer trouble
	vpr_hold_timer #(
		.HOLD_CYCLES (HOLD_CYCLES)
	) u_lvdt_hold (
		.clk    (REF_CLK),
		.rst_n  (NRST),
		.trig   (lvdt_trig),
		.active (lvdt_hold)
	);

	// five second hold for failover in either direction
	vpr_hold_timer #(
		.HOLD_CYCLES (HOLD_CYCLES)
	) u_fail_hold (
		.clk    (REF_CLK),
		.rst_n  (NRST),
		.trig   (fail_trig),
		.active (fail_hold)
	);

	// demand and mode mismatch flags follow their conditions
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			demand_err_ff <= 1'b0;
			mode_mm_ff    <= 1'b0;
		end else begin
			demand_err_ff <= REDUNDANT && (HOST_DEMAND != LINK_DEMAND);
			mode_mm_ff    <= REDUNDANT && (
				(mode_class(mode_ff) == vpr_pkg::VPR_CLS_NORMAL &&
				 mode_class(PARTNER_MODE) == vpr_pkg::VPR_CLS_LOCAL) ||
				(mode_class(mode_ff) == vpr_pkg::VPR_CLS_LOCAL &&
				 mode_class(PARTNER_MODE) == vpr_pkg::VPR_CLS_NORMAL));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// nonvolatile write done

	// set by completion, cleared when the next write starts; set wins
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			nv_done_ff <= 1'b0;
		end else if (NV_WRITE_DONE) begin
			nv_done_ff <= 1'b1;
		end else if (NV_WRITE_START) begin
			nv_done_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// primary status word

	// assemble the word; test mode keeps only the mode field
	always_comb begin
		nxt_stat                      = `VPR_RST_WORD;
		nxt_stat[3:0]                 = mode_ff;
		nxt_stat[`VPR_BIT_SHUTDOWN]   = shutdown;
		nxt_stat[`VPR_BIT_AUX_SENSE]  = aux_sense;
		nxt_stat[`VPR_BIT_SLIM_EN]    = slim_en;
		nxt_stat[`VPR_BIT_ALIVE]      = alive_ff;
		nxt_stat[`VPR_BIT_AT_NULL]    = AT_NULL;
		nxt_stat[`VPR_BIT_QUALITY]    = QUALITY_BAD;
		nxt_stat[`VPR_BIT_BACKUP]     = UNIT_BACKUP;
		nxt_stat[`VPR_BIT_LVDT]       = lvdt_hold;
		nxt_stat[`VPR_BIT_FAILOVER]   = fail_hold;
		nxt_stat[`VPR_BIT_DEMAND_ERR] = demand_err_ff;
		nxt_stat[`VPR_BIT_MODE_MM]    = mode_mm_ff;
		nxt_stat[`VPR_BIT_NV_DONE]    = nv_done_ff;
		if (test_mode) begin
			nxt_stat[15:4] = TEST_STATUS[15:4];
		end
	end

	// status register
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			stat_ff <= {12'h000, `VPR_RST_MODE};
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// indirect ram

	// pointer register, written by the host at offset 0
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			ptr_ff <= `VPR_RST_WORD;
		end else if (HOST_WR && HOST_ADDR == `VPR_OFF_RAM_PTR) begin
			ptr_ff <= HOST_WDATA;
		end
	end

	// data word at the pointed location, written at offset 1
	always_ff @(posedge REF_CLK) begin
		if (HOST_WR && HOST_ADDR == `VPR_OFF_RAM_DATA) begin
			ram[ptr_ff[PW-1:0]] <= HOST_WDATA;
		end
	end

	// device side read port
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			dev_rdata_ff <= `VPR_RST_WORD;
		end else begin
			dev_rdata_ff <= ram[DEV_RAM_ADDR[PW-1:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host read path

	// read mux; unmapped offsets read as zero
	always_comb begin
		case (HOST_ADDR)
			`VPR_OFF_RAM_PTR:    nxt_rdata = ptr_ff;
			`VPR_OFF_RAM_DATA:   nxt_rdata = ram[ptr_ff[PW-1:0]];
			`VPR_OFF_POS_FB:     nxt_rdata = pos_fb_ff;
			`VPR_OFF_COIL_ONE:   nxt_rdata = coil_one_ff;
			`VPR_OFF_COIL_TWO:   nxt_rdata = coil_two_ff;
			`VPR_OFF_COIL_THREE: nxt_rdata = coil_three_ff;
			`VPR_OFF_DEMOD:      nxt_rdata = demod_ff;
			`VPR_OFF_STAT2:      nxt_rdata = `VPR_RST_WORD;
			`VPR_OFF_STAT1:      nxt_rdata = stat_ff;
			default:             nxt_rdata = `VPR_RST_WORD;
		endcase
	end

	// read data is captured on the strobe and touches no other state
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rdata_ff <= `VPR_RST_WORD;
		end else if (HOST_RD) begin
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign HOST_RDATA    = rdata_ff;
	assign DEV_RAM_RDATA = dev_rdata_ff;
	assign RAM_PUT_PTR   = ptr_ff;
	assign STATUS_WORD   = stat_ff;

endmodule

// file: tb/vpr_host_regs_chk.sv
// port assertions for the host register bank
// assumes one clock REF_CLK and synchronous active-low NRST
`timescale 1ns/1ps
module vpr_host_regs_chk #(
	parameter int HOLD_CYCLES  = 20,
	parameter int ALIVE_CYCLES = 8
) (
	// clock and reset
	input wire logic               REF_CLK,
	input wire logic               NRST,
	// host port
	input wire logic [3:0]         HOST_ADDR,
	input wire logic               HOST_RD,
	input wire logic               HOST_WR,
	input wire vpr_pkg::vpr_word_t HOST_WDATA,
	input wire vpr_pkg::vpr_word_t HOST_RDATA,
	// causes
	input wire logic               SHUTDOWN_IN,
	input wire logic               FW_RUNNING,
	input wire vpr_pkg::vpr_mode_t FW_MODE,
	input wire logic               AT_NULL,
	input wire logic               REDUNDANT,
	input wire vpr_pkg::vpr_word_t HOST_DEMAND,
	input wire vpr_pkg::vpr_word_t LINK_DEMAND,
	// results
	input wire logic [15:0]        RAM_PUT_PTR,
	input wire vpr_pkg::vpr_word_t STATUS_WORD
);
	localparam int ALIVE_WIN = 2 * ALIVE_CYCLES + 4;

	////////////////////////////////////////
	// one clock domain for every property
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);

	// steady valid mode request, pin held, normal layout
	sequence s_mode_steady;
		($stable(FW_MODE) && FW_MODE inside {4'h1, 4'h2, 4'h3, [4'h8:4'hf]})[*3];
	endsequence
	sequence s_not_test;
		STATUS_WORD[3:0] != 4'h3;
	endsequence
	sequence s_pin_high;
		SHUTDOWN_IN[*4];
	endsequence

	////////////////////////////////////////
	// status word fields follow their causes
	a_mode_code: assert property (s_mode_steady |-> STATUS_WORD[3:0] == FW_MODE)
		else $error("mode field does not follow the requested mode");
	a_shutdown_bit: assert property (s_pin_high ##0 s_not_test |-> STATUS_WORD[4])
		else $error("shutdown bit low while pin held high");
	a_null_bit: assert property (AT_NULL ##1 s_not_test |-> STATUS_WORD[8])
		else $error("null point bit missing");
	a_demand_err: assert property ((REDUNDANT && HOST_DEMAND != LINK_DEMAND)[*3]
		##0 s_not_test |-> STATUS_WORD[13])
		else $error("demand mismatch bit missing");
	a_alive_toggle: assert property (FW_RUNNING[*8] ##0 s_not_test |-> ##[1:ALIVE_WIN]
		($changed(STATUS_WORD[7]) || !FW_RUNNING || STATUS_WORD[3:0] == 4'h3))
		else $error("alive bit stopped toggling");

	// host port answers
	a_ptr_write: assert property (HOST_WR && HOST_ADDR == 4'h0 |=> RAM_PUT_PTR == $past(HOST_WDATA))
		else $error("pointer write not taken");
	a_ptr_hold: assert property (!(HOST_WR && HOST_ADDR == 4'h0) |=> $stable(RAM_PUT_PTR))
		else $error("pointer changed without a write");
	a_stat2_zero: assert property (HOST_RD && HOST_ADDR == 4'h7 |=> HOST_RDATA == 16'h0000)
		else $error("secondary status not zero");
	a_status_read: assert property (HOST_RD && HOST_ADDR == 4'h8 |=> HOST_RDATA == $past(STATUS_WORD))
		else $error("status read differs from status word");
	a_coil_red: assert property (HOST_RD && REDUNDANT && HOST_ADDR inside {4'h4, 4'h5}
		|=> HOST_RDATA == 16'h0000)
		else $error("coil two or three shown while redundant");
endmodule

bind vpr_host_regs vpr_host_regs_chk #(.HOLD_CYCLES(HOLD_CYCLES), .ALIVE_CYCLES(ALIVE_CYCLES))
	vpr_host_regs_chk_inst (.*);

// file: tb/vpr_host_model.sv
// plant controller model: word reads and writes on the shared memory port
// assumes its tasks are entered just after a rising REF_CLK edge
`timescale 1ns/1ps
module vpr_host_model (
	// clock
	input  wire logic               REF_CLK,
	// shared memory port
	output logic [3:0]              HOST_ADDR,
	output logic                    HOST_RD,
	output logic                    HOST_WR,
	output vpr_pkg::vpr_word_t      HOST_WDATA,
	input  wire vpr_pkg::vpr_word_t HOST_RDATA
);
	////////////////////////////////////////
	// bus quiet at time zero
	initial begin
		{HOST_RD, HOST_WR, HOST_ADDR} = 6'h00;
		HOST_WDATA = 16'h0000;
	end

	// calibration command and partner alive copy live above offset 8, not driven here
	// one word access, pointer at 0 and data at 1; strobe stays up for a following access
	task automatic acc(input logic w, input logic [3:0] a, input vpr_pkg::vpr_word_t d,
		output vpr_pkg::vpr_word_t q);
		HOST_WR = w;
		HOST_RD = !w;
		HOST_ADDR = a;
		HOST_WDATA = d;
		@(posedge REF_CLK);
		#1;
		q = HOST_RDATA;
	endtask

	// release: address and data flip so stale values never look live
	task automatic idle();
		HOST_WR = 1'b0;
		HOST_RD = 1'b0;
		HOST_ADDR = ~HOST_ADDR;
		HOST_WDATA = ~HOST_WDATA;
	endtask
endmodule

// file: tb/vpr_host_regs_tb.sv
// self-checking bench for the host register bank
// assumes the design under logic/, host model and checker under tb/
`timescale 1ns/1ps
module vpr_host_regs_tb;
	localparam int HOLD = 20;

	////////////////////////////////////////
	// design signals and bench state
	logic REF_CLK = 1'b0;
	logic NRST = 1'b0;
	logic [3:0] HOST_ADDR;
	logic HOST_RD, HOST_WR, SHUTDOWN_IN, AUX_SENSE_IN, SLIM_EN_IN, FW_RUNNING, AT_NULL;
	logic NV_WRITE_START, NV_WRITE_DONE, REDUNDANT, UNIT_BACKUP, QUALITY_BAD, LVDT_FAULT;
	logic signed [15:0] POS_PCT_Q8;
	vpr_pkg::vpr_word_t HOST_WDATA, HOST_RDATA, COIL_ONE, COIL_TWO, COIL_THREE, DEMOD_RAW;
	vpr_pkg::vpr_word_t TEST_STATUS, HOST_DEMAND, LINK_DEMAND, DEV_RAM_RDATA, STATUS_WORD;
	vpr_pkg::vpr_mode_t FW_MODE, PARTNER_MODE;
	logic [15:0] DEV_RAM_ADDR, RAM_PUT_PTR;
	vpr_pkg::vpr_word_t q, e;
	logic [15:0] rnd = 16'h000b;
	logic signed [15:0] pc [6] = '{-16'sd1280, 16'sd26880, -16'sd2560, 16'sd28160,
		16'sh8000, 16'sh7fff};
	int n_errors = 0;
	int checks_done = 0;
	int n;

	// design and host model
	vpr_host_regs #(.HOLD_CYCLES(HOLD), .ALIVE_CYCLES(8)) vpr_host_regs_inst (.*);
	vpr_host_model vpr_host_model_inst (.*);

	// 50 ns clock
	always #25 REF_CLK = ~REF_CLK;

	////////////////////////////////////////
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic vpr_pkg::vpr_word_t pos_exp(input logic signed [15:0] p);
		int v;
		v = (int'(p) * 312) >>> 8;
		if (v < -1560) v = -1560;
		if (v > 32760) v = 32760;
		return v[15:0];
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge REF_CLK);
		#1;
	endtask
	task automatic chk(input vpr_pkg::vpr_word_t got, input vpr_pkg::vpr_word_t exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input vpr_pkg::vpr_word_t d);
		vpr_host_model_inst.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, output vpr_pkg::vpr_word_t d);
		vpr_host_model_inst.acc(1'b0, a, 16'h0000, d);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// length of a held status bit, bounded waits
	task automatic hold_len(input int b, output int k);
		int t;
		t = 0;
		k = 0;
		while (STATUS_WORD[b] !== 1'b1 && t < 10) begin
			cyc(1);
			t++;
		end
		while (STATUS_WORD[b] === 1'b1 && k < 100) begin
			cyc(1);
			k++;
		end
		if (t >= 10 || k >= 100) begin
			n_errors++;
			$display("[FAIL] %0t held bit %0d never rose or never fell", $time, b);
			end_sim();
		end
	endtask

	////////////////////////////////////////
	// main sequence
	initial begin
		{SHUTDOWN_IN, AUX_SENSE_IN, SLIM_EN_IN, FW_RUNNING, AT_NULL, NV_WRITE_START} = '0;
		{NV_WRITE_DONE, REDUNDANT, UNIT_BACKUP, QUALITY_BAD, LVDT_FAULT} = '0;
		{POS_PCT_Q8, COIL_ONE, COIL_TWO, COIL_THREE, DEMOD_RAW, TEST_STATUS} = '0;
		{HOST_DEMAND, LINK_DEMAND, DEV_RAM_ADDR} = '0;
		FW_MODE = 4'h1;
		PARTNER_MODE = 4'hc;
		cyc(3);
		chk(STATUS_WORD, 16'h0001, "reset status");
		chk(RAM_PUT_PTR, 16'h0000, "reset pointer");
		NRST = 1'b1;
		// pointer then data back to back, unmapped read
		rnd = lfsr(rnd);
		wr(4'h0, rnd);
		wr(4'h1, ~rnd);
		rd(4'h1, q);
		chk(q, ~rnd, "indirect data");
		rd(4'h9, q);
		vpr_host_model_inst.idle();
		chk(q, 16'h0000, "unmapped read");
		chk(RAM_PUT_PTR, rnd, "put pointer");
		DEV_RAM_ADDR = rnd;
		cyc(2);
		chk(DEV_RAM_RDATA, ~rnd, "device ram view");
		$display("test pointer done");
		// position corners then random, refused write to the same word
		for (int i = 0; i < 14; i++) begin
			rnd = lfsr(rnd);
			POS_PCT_Q8 = (i < 6) ? pc[i] : rnd;
			wr(4'h2, rnd);
			rd(4'h2, q);
			chk(q, pos_exp(POS_PCT_Q8), "position feedback");
		end
		vpr_host_model_inst.idle();
		$display("test position done");
		// measurement words, non-redundant then redundant
		for (int r = 0; r < 2; r++) begin
			rnd = lfsr(rnd);
			REDUNDANT = r[0];
			{COIL_ONE, COIL_TWO, COIL_THREE, DEMOD_RAW} = {rnd, ~rnd, rnd ^ 16'h5a5a, rnd + 16'h1};
			cyc(1);
			for (int a = 3; a < 8; a++) begin
				case (a)
					3: e = COIL_ONE;
					4: e = r ? 16'h0000 : COIL_TWO;
					5: e = r ? 16'h0000 : COIL_THREE;
					6: e = DEMOD_RAW;
					default: e = 16'h0000;
				endcase
				rd(a[3:0], q);
				chk(q, e, "measurement word");
			end
			vpr_host_model_inst.idle();
		end
		REDUNDANT = 1'b0;
		$display("test measurements done");
		// every mode code, invalid ones ignored, test layout
		e = 16'h0001;
		for (int m = 0; m < 16; m++) begin
			rnd = lfsr(rnd);
			FW_MODE = m[3:0];
			TEST_STATUS = rnd;
			cyc(3);
			if (!(m inside {0, [4:7]})) e[3:0] = m[3:0];
			chk(STATUS_WORD[3:0], e[3:0], "mode field");
			if (m == 3) chk(STATUS_WORD[15:4], TEST_STATUS[15:4], "test layout");
		end
		FW_MODE = 4'h8;
		$display("test modes done");
		// pins and level flags, status read twice
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			{SHUTDOWN_IN, AUX_SENSE_IN, SLIM_EN_IN, AT_NULL, QUALITY_BAD, UNIT_BACKUP} = rnd[5:0];
			cyc(4);
			chk({STATUS_WORD[10:8], STATUS_WORD[6:4]}, {UNIT_BACKUP, QUALITY_BAD, AT_NULL,
				SLIM_EN_IN, AUX_SENSE_IN, SHUTDOWN_IN}, "flag bits");
			rd(4'h8, q);
			rd(4'h8, e);
			vpr_host_model_inst.idle();
			chk(q, e, "status read twice");
		end
		$display("test flags done");
		// alive bit toggles while firmware runs
		FW_RUNNING = 1'b1;
		for (int j = 0; j < 3; j++) begin
			e = STATUS_WORD;
			n = 0;
			while (STATUS_WORD[7] === e[7] && n < 40) begin
				cyc(1);
				n++;
			end
			chk(n < 40, 1'b1, "alive toggle");
		end
		$display("test alive done");
		// role change both ways, transducer fault, held for the hold count
		REDUNDANT = 1'b1;
		cyc(2);
		for (int j = 0; j < 2; j++) begin
			UNIT_BACKUP = ~UNIT_BACKUP;
			hold_len(12, n);
			chk(16'(n), 16'(HOLD), "failover hold");
		end
		LVDT_FAULT = 1'b1;
		hold_len(11, n);
		chk(16'(n), 16'(HOLD), "transducer hold");
		LVDT_FAULT = 1'b0;
		$display("test holds done");
		// demand and mode mismatch, set then clear
		for (int j = 0; j < 2; j++) begin
			rnd = lfsr(rnd);
			HOST_DEMAND = rnd;
			LINK_DEMAND = j ? rnd : ~rnd;
			PARTNER_MODE = j ? 4'h8 : 4'hd;
			cyc(3);
			chk(STATUS_WORD[13], !j, "demand mismatch");
			chk(STATUS_WORD[14], !j, "mode mismatch");
		end
		$display("test mismatch done");
		// mid-run reset with the backup role high: no false failover after release
		NRST = 1'b0;
		UNIT_BACKUP = 1'b1;
		cyc(2);
		chk(STATUS_WORD, 16'h0001, "status in reset");
		chk(RAM_PUT_PTR, 16'h0000, "pointer in reset");
		chk(HOST_RDATA, 16'h0000, "read data in reset");
		NRST = 1'b1;
		cyc(3);
		chk(STATUS_WORD[12], 1'b0, "no failover after reset");
		$display("test reset done");
		// nonvolatile write start then completion
		NV_WRITE_START = 1'b1;
		cyc(1);
		NV_WRITE_START = 1'b0;
		cyc(2);
		chk(STATUS_WORD[15], 1'b0, "write pending");
		NV_WRITE_DONE = 1'b1;
		cyc(1);
		NV_WRITE_DONE = 1'b0;
		cyc(2);
		chk(STATUS_WORD[15], 1'b1, "write complete");
		// completion and next start in one cycle: set wins, then start alone clears
		{NV_WRITE_START, NV_WRITE_DONE} = 2'b11;
		cyc(1);
		{NV_WRITE_START, NV_WRITE_DONE} = 2'b00;
		cyc(2);
		chk(STATUS_WORD[15], 1'b1, "set wins over clear");
		NV_WRITE_START = 1'b1;
		cyc(1);
		NV_WRITE_START = 1'b0;
		cyc(2);
		chk(STATUS_WORD[15], 1'b0, "cleared by next write");
		$display("test nonvolatile done");
		end_sim();
	end
endmodule
